/* logic/msr_regs.sv */
// Modbus status and control register bank of the video encoder
//
// Functional notes
// [RULE1] Function codes 3 and 4 read identically
// [RULE2] Power words: 0 absent, 1 present
// [RULE3] Fault word reads 1 while fault asserted
// [RULE4] Video presence words for channels one-four
// [RULE5] Four digital input words reflect input state
// [RULE6] Relay words write open/close, read state
// [RULE7] Duration words per channel, range 1 to 999
// [RULE8] Control words: 1 always run, 0 stopped
// [RULE9] Port words: down, up, disabled, absent
// [RULE10] Bad writes get exception, contents unchanged
`timescale 1ns/1ps
`default_nettype none

module msr_regs
#(
    parameter int unsigned DUR_MAX_P = 999
)
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Status pins, asynchronous to clock
    input  wire msr_pkg::msr_pins_s pins,
    // Modbus request, one word per request
    input  wire logic              req_valid,
    input  wire msr_pkg::msr_req_s  req,
    // Modbus answer
    output logic                   rsp_valid,
    output msr_pkg::msr_rsp_s       rsp,
    // Controlled outputs
    output logic [1:0]             relay_close,
    output msr_pkg::msr_dur_t       rate_duration,
    output logic [3:0]             rate_run
);
    import msr_pkg::*;

    if (DUR_MAX_P < 1 || DUR_MAX_P > 65535)
    begin : g_bad_dur_max
        $error("DUR_MAX_P must lie in 1..65535");
    end

    localparam logic [15:0] DUR_MAX = 16'(DUR_MAX_P);

    function automatic logic [15:0] flag_word(input logic b);
        flag_word = b ? MSR_WORD_ON : MSR_WORD_OFF;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser: a change counts once stages two and three agree

    msr_pins_s sync1_q;
    msr_pins_s sync2_q;
    msr_pins_s sync3_q;
    msr_pins_s pins_q;
    msr_pins_s pins_d;

    always_comb
    begin
        // Hold the last agreed level while the two late stages disagree
        pins_d = (sync2_q & sync3_q) | (pins_q & (sync2_q | sync3_q));
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            pins_q  <= '0;
        end
        else
        begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pins_q  <= pins_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode, write checks and next register values

    logic [1:0]  relay_q;
    logic [1:0]  relay_d;
    msr_dur_t    dur_q;
    msr_dur_t    dur_d;
    logic [3:0]  run_q;
    logic [3:0]  run_d;
    logic        rd_hit;
    logic        wr_able;
    logic        val_ok;
    logic        wr_go;
    logic        is_read;
    logic [15:0] rd_word;
    logic [15:0] port_word [2];

    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            // Absent beats disabled beats link state
            if (!pins_q.port_fitted[p])
                port_word[p] = MSR_PORT_ABSENT;  // [RULE9]
            else if (!pins_q.port_enabled[p])
                port_word[p] = MSR_PORT_DISABLED;  // [RULE9]
            else
                port_word[p] = flag_word(pins_q.port_link_up[p]);  // [RULE9]
        end
    end

    always_comb
    begin
        is_read = (req.fc == MSR_FC_READ_HOLDING) || (req.fc == MSR_FC_READ_INPUT);  // [RULE1]
        wr_go   = req_valid && (req.fc == MSR_FC_WRITE_SINGLE);
        rd_hit  = 1'b1;
        wr_able = 1'b0;
        val_ok  = 1'b0;
        rd_word = MSR_WORD_OFF;
        relay_d = relay_q;
        dur_d   = dur_q;
        run_d   = run_q;
        case (req.addr)
            MSR_ADDR_POWER_INPUT_ONE_STATUS: rd_word = flag_word(pins_q.power_present[0]);  // [RULE2]
            MSR_ADDR_POWER_INPUT_TWO_STATUS: rd_word = flag_word(pins_q.power_present[1]);  // [RULE2]
            MSR_ADDR_FAULT_INDICATOR_STATUS: rd_word = flag_word(pins_q.fault_active);  // [RULE3]
            MSR_ADDR_VIDEO_PRESENCE_CH1:     rd_word = flag_word(pins_q.video_present[0]);  // [RULE4]
            MSR_ADDR_VIDEO_PRESENCE_CH2:     rd_word = flag_word(pins_q.video_present[1]);  // [RULE4]
            MSR_ADDR_VIDEO_PRESENCE_CH3:     rd_word = flag_word(pins_q.video_present[2]);  // [RULE4]
            MSR_ADDR_VIDEO_PRESENCE_CH4:     rd_word = flag_word(pins_q.video_present[3]);  // [RULE4]
            MSR_ADDR_DIGITAL_INPUT_ONE:      rd_word = flag_word(pins_q.digital_in[0]);  // [RULE5]
            MSR_ADDR_DIGITAL_INPUT_TWO:      rd_word = flag_word(pins_q.digital_in[1]);  // [RULE5]
            MSR_ADDR_DIGITAL_INPUT_THREE:    rd_word = flag_word(pins_q.digital_in[2]);  // [RULE5]
            MSR_ADDR_DIGITAL_INPUT_FOUR:     rd_word = flag_word(pins_q.digital_in[3]);  // [RULE5]
            MSR_ADDR_NETWORK_PORT_ONE_LINK:  rd_word = port_word[0];  // [RULE9]
            MSR_ADDR_NETWORK_PORT_TWO_LINK:  rd_word = port_word[1];  // [RULE9]
            default:                         rd_hit = 1'b0;
        endcase
        for (int r = 0; r < 2; r++)
        begin
            if (req.addr == MSR_RELAY_ADDRS[r])
            begin
                rd_hit  = 1'b1;
                wr_able = 1'b1;
                rd_word = flag_word(relay_q[r]);  // [RULE6]
                val_ok  = (req.wdata <= MSR_WORD_ON);  // [RULE10]
                if (wr_go && val_ok)
                    relay_d[r] = req.wdata[0];  // [RULE6]
            end
        end
        for (int c = 0; c < 4; c++)
        begin
            if (req.addr == MSR_RATE_DUR_ADDRS[c])
            begin
                rd_hit  = 1'b1;
                wr_able = 1'b1;
                rd_word = dur_q[c];
                val_ok  = (req.wdata >= MSR_DUR_MIN) && (req.wdata <= DUR_MAX);  // [RULE7]
                if (wr_go && val_ok)
                    dur_d[c] = req.wdata;  // [RULE7]
            end
            if (req.addr == MSR_RATE_CTL_ADDRS[c])
            begin
                rd_hit  = 1'b1;
                wr_able = 1'b1;
                rd_word = flag_word(run_q[c]);
                val_ok  = (req.wdata <= MSR_WORD_ON);  // [RULE10]
                if (wr_go && val_ok)
                    run_d[c] = req.wdata[0];  // [RULE8]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Answer, one cycle after the request

    msr_rsp_s rsp_d;
    msr_rsp_s rsp_q;
    logic     rsp_valid_q;
    logic [7:0] exc_code;

    always_comb
    begin
        if (!is_read && req.fc != MSR_FC_WRITE_SINGLE)
            exc_code = MSR_EXC_ILLEGAL_FUNC;
        else if (!rd_hit || (!is_read && !wr_able))
            exc_code = MSR_EXC_ILLEGAL_ADDR;  // [RULE10]
        else if (!is_read && !val_ok)
            exc_code = MSR_EXC_ILLEGAL_VALUE;  // [RULE10]
        else
            exc_code = MSR_EXC_NONE;
        rsp_d.exc      = (exc_code != MSR_EXC_NONE);
        rsp_d.exc_code = exc_code;
        rsp_d.fc       = rsp_d.exc ? (req.fc | MSR_FC_EXC_FLAG) : req.fc;
        rsp_d.addr     = req.addr;
        // Same word for either read code; a write echoes its value
        if (rsp_d.exc)
            rsp_d.data = MSR_WORD_OFF;
        else if (is_read)
            rsp_d.data = rd_word;  // [RULE1]
        else
            rsp_d.data = req.wdata;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            relay_q     <= MSR_RELAY_RST;
            dur_q       <= {4{MSR_DUR_RST}};
            run_q       <= MSR_RUN_RST;
            rsp_valid_q <= 1'b0;
            rsp_q       <= '0;
        end
        else
        begin
            relay_q     <= relay_d;
            dur_q       <= dur_d;
            run_q       <= run_d;
            rsp_valid_q <= req_valid;
            if (req_valid)
                rsp_q <= rsp_d;
        end
    end

    assign rsp_valid     = rsp_valid_q;
    assign rsp           = rsp_q;
    assign relay_close   = relay_q;
    assign rate_duration = dur_q;
    assign rate_run      = run_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_read_codes_same;
        req_valid && is_read && (req.addr == MSR_ADDR_DIGITAL_INPUT_ONE) |=>
            rsp_valid && !rsp.exc && (rsp.data == {15'h0000, $past(pins_q.digital_in[0])});
    endproperty
    a_read_codes_same: assert property (p_read_codes_same) // [RULE1]
        else $error("read code 3 or 4 gave wrong word");

    property p_power_word;
        req_valid && is_read && (req.addr == MSR_ADDR_POWER_INPUT_TWO_STATUS) |=>
            rsp.data == {15'h0000, $past(pins_q.power_present[1])};
    endproperty
    a_power_word: assert property (p_power_word) // [RULE2]
        else $error("power word mismatch");

    property p_fault_word;
        req_valid && is_read && (req.addr == MSR_ADDR_FAULT_INDICATOR_STATUS) |=>
            rsp.data == {15'h0000, $past(pins_q.fault_active)};
    endproperty
    a_fault_word: assert property (p_fault_word) // [RULE3]
        else $error("fault word mismatch");

    property p_video_word;
        req_valid && is_read && (req.addr == MSR_ADDR_VIDEO_PRESENCE_CH4) |=>
            rsp.data == {15'h0000, $past(pins_q.video_present[3])};
    endproperty
    a_video_word: assert property (p_video_word) // [RULE4]
        else $error("video presence word mismatch");

    property p_relay_close;
        wr_go && (req.addr == MSR_ADDR_RELAY_OUTPUT_TWO) && (req.wdata == MSR_WORD_ON) |=>
            relay_close[1] && !rsp.exc && (rsp.data == MSR_WORD_ON);
    endproperty
    a_relay_close: assert property (p_relay_close) // [RULE6]
        else $error("relay did not close on write of one");

    property p_dur_range;
        wr_go && (req.addr == MSR_ADDR_RATE_DURATION_CH1) && (req.wdata == 16'h0000) |=>
            rsp.exc && (rsp.exc_code == MSR_EXC_ILLEGAL_VALUE) && $stable(rate_duration);
    endproperty
    a_dur_range: assert property (p_dur_range) // [RULE7]
        else $error("duration of zero was accepted");

    property p_run_write;
        wr_go && (req.addr == MSR_ADDR_RATE_CONTROL_CH2) && (req.wdata == MSR_WORD_OFF) |=>
            !rate_run[1];
    endproperty
    a_run_write: assert property (p_run_write) // [RULE8]
        else $error("control write of zero did not stop");

    property p_port_absent;
        req_valid && is_read && (req.addr == MSR_ADDR_NETWORK_PORT_ONE_LINK) && !pins_q.port_fitted[0] |=>
            rsp.data == MSR_PORT_ABSENT;
    endproperty
    a_port_absent: assert property (p_port_absent) // [RULE9]
        else $error("absent port not reported as all ones");

    property p_ro_write;
        wr_go && (req.addr == MSR_ADDR_DIGITAL_INPUT_THREE) |=>
            rsp.exc && (rsp.exc_code == MSR_EXC_ILLEGAL_ADDR) && $stable(relay_close) && $stable(rate_run);
    endproperty
    a_ro_write: assert property (p_ro_write) // [RULE10]
        else $error("write to read-only word not refused");

endmodule

`default_nettype wire

/* logic/msr_pkg.sv */
// Package for the Modbus status and control register bank
`default_nettype none

package msr_pkg;

    // Modbus function codes
    localparam logic [7:0] MSR_FC_READ_HOLDING = 8'h03;
    localparam logic [7:0] MSR_FC_READ_INPUT   = 8'h04;
    localparam logic [7:0] MSR_FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] MSR_FC_EXC_FLAG     = 8'h80;

    // Modbus exception codes
    localparam logic [7:0] MSR_EXC_NONE          = 8'h00;
    localparam logic [7:0] MSR_EXC_ILLEGAL_FUNC  = 8'h01;
    localparam logic [7:0] MSR_EXC_ILLEGAL_ADDR  = 8'h02;
    localparam logic [7:0] MSR_EXC_ILLEGAL_VALUE = 8'h03;

    // Register word addresses
    localparam logic [15:0] MSR_ADDR_POWER_INPUT_ONE_STATUS = 16'h0058;
    localparam logic [15:0] MSR_ADDR_POWER_INPUT_TWO_STATUS = 16'h0059;
    localparam logic [15:0] MSR_ADDR_FAULT_INDICATOR_STATUS = 16'h005A;
    localparam logic [15:0] MSR_ADDR_VIDEO_PRESENCE_CH1     = 16'h005B;
    localparam logic [15:0] MSR_ADDR_VIDEO_PRESENCE_CH2     = 16'h005C;
    localparam logic [15:0] MSR_ADDR_VIDEO_PRESENCE_CH3     = 16'h005D;
    localparam logic [15:0] MSR_ADDR_VIDEO_PRESENCE_CH4     = 16'h005E;
    localparam logic [15:0] MSR_ADDR_DIGITAL_INPUT_ONE      = 16'h0080;
    localparam logic [15:0] MSR_ADDR_DIGITAL_INPUT_TWO      = 16'h0081;
    localparam logic [15:0] MSR_ADDR_DIGITAL_INPUT_THREE    = 16'h0082;
    localparam logic [15:0] MSR_ADDR_DIGITAL_INPUT_FOUR     = 16'h0083;
    localparam logic [15:0] MSR_ADDR_RELAY_OUTPUT_ONE       = 16'h0088;
    localparam logic [15:0] MSR_ADDR_RELAY_OUTPUT_TWO       = 16'h0089;
    localparam logic [15:0] MSR_ADDR_RATE_DURATION_CH1      = 16'h0800;
    localparam logic [15:0] MSR_ADDR_RATE_CONTROL_CH1       = 16'h0801;
    localparam logic [15:0] MSR_ADDR_RATE_DURATION_CH2      = 16'h0802;
    localparam logic [15:0] MSR_ADDR_RATE_CONTROL_CH2       = 16'h0803;
    localparam logic [15:0] MSR_ADDR_RATE_DURATION_CH3      = 16'h0804;
    localparam logic [15:0] MSR_ADDR_RATE_CONTROL_CH3       = 16'h0805;
    localparam logic [15:0] MSR_ADDR_RATE_DURATION_CH4      = 16'h0806;
    localparam logic [15:0] MSR_ADDR_RATE_CONTROL_CH4       = 16'h0807;
    localparam logic [15:0] MSR_ADDR_NETWORK_PORT_ONE_LINK  = 16'h1000;
    localparam logic [15:0] MSR_ADDR_NETWORK_PORT_TWO_LINK  = 16'h1001;

    // Address groups for the per-channel and per-relay words, index 0 first
    localparam logic [1:0][15:0] MSR_RELAY_ADDRS =
        {MSR_ADDR_RELAY_OUTPUT_TWO, MSR_ADDR_RELAY_OUTPUT_ONE};
    localparam logic [3:0][15:0] MSR_RATE_DUR_ADDRS =
        {MSR_ADDR_RATE_DURATION_CH4, MSR_ADDR_RATE_DURATION_CH3,
         MSR_ADDR_RATE_DURATION_CH2, MSR_ADDR_RATE_DURATION_CH1};
    localparam logic [3:0][15:0] MSR_RATE_CTL_ADDRS =
        {MSR_ADDR_RATE_CONTROL_CH4, MSR_ADDR_RATE_CONTROL_CH3,
         MSR_ADDR_RATE_CONTROL_CH2, MSR_ADDR_RATE_CONTROL_CH1};

    // Word values
    localparam logic [15:0] MSR_WORD_OFF      = 16'h0000;
    localparam logic [15:0] MSR_WORD_ON       = 16'h0001;
    localparam logic [15:0] MSR_PORT_DISABLED = 16'h0002;
    localparam logic [15:0] MSR_PORT_ABSENT   = 16'hFFFF;
    localparam logic [15:0] MSR_DUR_MIN       = 16'h0001;
    localparam logic [15:0] MSR_DUR_MAX       = 16'h03E7;

    // Values after reset
    localparam logic [1:0]       MSR_RELAY_RST = 2'h0;
    localparam logic [15:0]      MSR_DUR_RST   = 16'h0001;
    localparam logic [3:0]       MSR_RUN_RST   = 4'h0;

    // Pin input synchroniser depth
    localparam int unsigned MSR_SYNC_STAGES = 3;

    typedef logic [3:0][15:0] msr_dur_t;

    // Status pins, gathered so they synchronise as one vector
    typedef struct packed {
        logic [1:0] port_link_up;
        logic [1:0] port_enabled;
        logic [1:0] port_fitted;
        logic [3:0] digital_in;
        logic [3:0] video_present;
        logic       fault_active;
        logic [1:0] power_present;
    } msr_pins_s;

    typedef struct packed {
        logic [7:0]  fc;
        logic [15:0] addr;
        logic [15:0] wdata;
    } msr_req_s;

    typedef struct packed {
        logic [7:0]  fc;
        logic        exc;
        logic [7:0]  exc_code;
        logic [15:0] addr;
        logic [15:0] data;
    } msr_rsp_s;

endpackage

`default_nettype wire

/* sim/msr_client_model.sv */
// Modbus client model issuing single-word requests to the register bank
`timescale 1ns/1ps
`default_nettype none

module msr_client_model
    import msr_pkg::*;
(
    // Clock
    input  wire logic              clock,
    // Request side
    output var  msr_pkg::msr_req_s req,
    output var  logic              req_valid,
    // Answer side
    input  wire logic              rsp_valid,
    input  wire msr_pkg::msr_rsp_s rsp
);
    initial
    begin
        req_valid = 1'b0;
        req       = '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Values written come from the caller; only refusal scenarios step outside
    // the legal sets
    task automatic xfer(input logic [7:0] fc, input logic [15:0] addr, input logic [15:0] wd,
                        output msr_rsp_s got, output logic seen);
        @(posedge clock);
        req_valid <= 1'b1;
        req       <= '{fc: fc, addr: addr, wdata: wd};
        @(posedge clock);
        req_valid <= 1'b0;
        // Released fields flip so a stale request never looks valid
        req       <= ~req;
        #1;
        seen = rsp_valid;
        got  = rsp;
    endtask
endmodule

`default_nettype wire

/* sim/tb_modbus_status_control_regs.sv */
// Self-checking testbench for the Modbus status and control register bank
`timescale 1ns/1ps
`default_nettype none

module tb_modbus_status_control_regs;
    import msr_pkg::*;
    logic       clock;
    logic       rst;
    msr_pins_s  pins;
    logic       req_valid;
    msr_req_s   req;
    logic       rsp_valid;
    msr_rsp_s   rsp;
    logic [1:0] relay_close;
    msr_dur_t   rate_duration;
    logic [3:0] rate_run;
    int         err_total;
    int         samples_checked;

    msr_regs #(.DUR_MAX_P(999)) i_dut (.clock(clock), .rst(rst), .pins(pins), .req_valid(req_valid),
        .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .relay_close(relay_close),
        .rate_duration(rate_duration), .rate_run(rate_run));
    msr_client_model i_client (.clock(clock), .req(req), .req_valid(req_valid),
        .rsp_valid(rsp_valid), .rsp(rsp));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One transfer; code 0 means a normal answer carrying exp
    task automatic op(input logic [7:0] fc, input logic [15:0] addr, input logic [15:0] wd,
                      input logic [7:0] code, input logic [15:0] exp);
        msr_rsp_s got;
        logic     seen;
        i_client.xfer(fc, addr, wd, got, seen);
        chk({15'h0000, seen}, 16'h0001, "answer one cycle after request");
        chk({8'h00, got.fc}, {8'h00, (code != 8'h00) ? (fc | MSR_FC_EXC_FLAG) : fc}, "function code");
        chk({15'h0000, got.exc}, {15'h0000, code != 8'h00}, "exception flag");
        chk({8'h00, got.exc_code}, {8'h00, code}, "exception code");
        chk(got.data, (code != 8'h00) ? 16'h0000 : exp, "answer data");
        chk(got.addr, addr, "address echo");
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        @(posedge clock);
        #1;
        chk({14'h0000, relay_close}, 16'h0000, "relays open after reset");
        chk({12'h000, rate_run}, 16'h0000, "controls stopped after reset");
        for (int c = 0; c < 4; c++)
        begin
            chk(rate_duration[c], 16'h0001, "duration after reset");
            op(MSR_FC_READ_HOLDING, MSR_RATE_DUR_ADDRS[c], 16'h0000, 8'h00, 16'h0001);
            op(MSR_FC_READ_INPUT, MSR_RATE_CTL_ADDRS[c], 16'h0000, 8'h00, 16'h0000);
        end
    endtask

    // Every status word read under both read codes
    task automatic t_status(input msr_pins_s p);
        logic [15:0] pe [2];
        logic [7:0]  fc;
        for (int k = 0; k < 2; k++)
            pe[k] = !p.port_fitted[k] ? 16'hFFFF : !p.port_enabled[k] ? 16'h0002 : {15'h0000, p.port_link_up[k]};
        @(posedge clock);
        pins <= p;
        // Sync chain plus margin
        repeat (6) @(posedge clock);
        for (int f = 0; f < 2; f++)
        begin
            fc = (f == 0) ? MSR_FC_READ_HOLDING : MSR_FC_READ_INPUT;
            for (int k = 0; k < 2; k++)
            begin
                op(fc, MSR_ADDR_POWER_INPUT_ONE_STATUS + 16'(k), 16'h0000, 8'h00, {15'h0000, p.power_present[k]});
                op(fc, MSR_ADDR_NETWORK_PORT_ONE_LINK + 16'(k), 16'h0000, 8'h00, pe[k]);
            end
            op(fc, MSR_ADDR_FAULT_INDICATOR_STATUS, 16'h0000, 8'h00, {15'h0000, p.fault_active});
            for (int k = 0; k < 4; k++)
            begin
                op(fc, MSR_ADDR_VIDEO_PRESENCE_CH1 + 16'(k), 16'h0000, 8'h00, {15'h0000, p.video_present[k]});
                op(fc, MSR_ADDR_DIGITAL_INPUT_ONE + 16'(k), 16'h0000, 8'h00, {15'h0000, p.digital_in[k]});
            end
        end
    endtask

    task automatic t_control();
        for (int r = 0; r < 2; r++)
        begin
            op(MSR_FC_WRITE_SINGLE, MSR_RELAY_ADDRS[r], 16'h0001, 8'h00, 16'h0001);
            chk({14'h0000, relay_close}, 16'(1 << r), "relay closed");
            op(MSR_FC_READ_INPUT, MSR_RELAY_ADDRS[r], 16'h0000, 8'h00, 16'h0001);
            op(MSR_FC_WRITE_SINGLE, MSR_RELAY_ADDRS[r], 16'h0000, 8'h00, 16'h0000);
            chk({14'h0000, relay_close}, 16'h0000, "relay opened");
        end
        for (int c = 0; c < 4; c++)
        begin
            op(MSR_FC_WRITE_SINGLE, MSR_RATE_DUR_ADDRS[c], 16'h03E7 - 16'(c), 8'h00, 16'h03E7 - 16'(c));
            chk(rate_duration[c], 16'h03E7 - 16'(c), "duration stored");
            op(MSR_FC_WRITE_SINGLE, MSR_RATE_CTL_ADDRS[c], 16'h0001, 8'h00, 16'h0001);
            chk({15'h0000, rate_run[c]}, 16'h0001, "control running");
            op(MSR_FC_READ_HOLDING, MSR_RATE_DUR_ADDRS[c], 16'h0000, 8'h00, 16'h03E7 - 16'(c));
        end
        op(MSR_FC_WRITE_SINGLE, MSR_RATE_CTL_ADDRS[0], 16'h0000, 8'h00, 16'h0000);
        chk({12'h000, rate_run}, 16'h000E, "channel one stopped");
        op(MSR_FC_WRITE_SINGLE, MSR_RATE_DUR_ADDRS[0], 16'h0001, 8'h00, 16'h0001);
    endtask

    // Refused requests must leave contents as they were
    task automatic t_refuse();
        op(MSR_FC_WRITE_SINGLE, MSR_ADDR_FAULT_INDICATOR_STATUS, 16'h0001, MSR_EXC_ILLEGAL_ADDR, 16'h0000);
        op(MSR_FC_WRITE_SINGLE, MSR_ADDR_NETWORK_PORT_TWO_LINK, 16'h0001, MSR_EXC_ILLEGAL_ADDR, 16'h0000);
        op(MSR_FC_WRITE_SINGLE, MSR_ADDR_DIGITAL_INPUT_THREE, 16'h0001, MSR_EXC_ILLEGAL_ADDR, 16'h0000);
        op(MSR_FC_WRITE_SINGLE, MSR_RATE_DUR_ADDRS[1], 16'h0000, MSR_EXC_ILLEGAL_VALUE, 16'h0000);
        op(MSR_FC_WRITE_SINGLE, MSR_RATE_DUR_ADDRS[0], 16'h0000, MSR_EXC_ILLEGAL_VALUE, 16'h0000);
        chk(rate_duration[0], 16'h0001, "zero duration refused");
        op(MSR_FC_WRITE_SINGLE, MSR_RATE_DUR_ADDRS[1], 16'h03E8, MSR_EXC_ILLEGAL_VALUE, 16'h0000);
        op(MSR_FC_WRITE_SINGLE, MSR_RATE_CTL_ADDRS[1], 16'h0002, MSR_EXC_ILLEGAL_VALUE, 16'h0000);
        op(MSR_FC_WRITE_SINGLE, MSR_RELAY_ADDRS[1], 16'h0002, MSR_EXC_ILLEGAL_VALUE, 16'h0000);
        op(8'h10, MSR_ADDR_POWER_INPUT_ONE_STATUS, 16'h0000, MSR_EXC_ILLEGAL_FUNC, 16'h0000);
        op(MSR_FC_READ_HOLDING, 16'h0100, 16'h0000, MSR_EXC_ILLEGAL_ADDR, 16'h0000);
        chk(rate_duration[1], 16'h03E6, "duration unchanged");
        chk({12'h000, rate_run}, 16'h000E, "controls unchanged");
        chk({14'h0000, relay_close}, 16'h0000, "relays unchanged");
        op(MSR_FC_READ_INPUT, MSR_RATE_DUR_ADDRS[1], 16'h0000, 8'h00, 16'h03E6);
        op(MSR_FC_WRITE_SINGLE, MSR_RATE_CTL_ADDRS[1], 16'h0000, 8'h00, 16'h0000);
        chk({12'h000, rate_run}, 16'h000C, "channel two stopped");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge clock);
        err_total++;
        $display("ERROR %0t: run did not finish in time", $time);
        final_report();
    end

    initial
    begin
        err_total       = 0;
        samples_checked = 0;
        rst             = 1'b1;
        pins            = '0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_status(msr_pins_s'{port_link_up: 2'b01, port_enabled: 2'b01, port_fitted: 2'b11, digital_in: 4'hA,
                             video_present: 4'h5, fault_active: 1'b1, power_present: 2'b01});
        t_status(msr_pins_s'{port_link_up: 2'b01, port_enabled: 2'b10, port_fitted: 2'b10, digital_in: 4'h5,
                             video_present: 4'hA, fault_active: 1'b0, power_present: 2'b10});
        t_control();
        t_refuse();
        final_report();
    end
endmodule

`default_nettype wire
